// ==== common/srm_pkg.sv ====
package srm_pkg;

	// ------------------------------------------------------------
	// frame and storage geometry
	// ------------------------------------------------------------
	localparam int SRM_FRAME_BITS  = 24;
	localparam int SRM_BYTE_BITS   = 8;
	localparam int SRM_ADDR_BITS   = 7;
	localparam int SRM_DEPTH       = 128;
	localparam int SRM_CTRL_BIT    = 7;
	localparam int SRM_SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// first frame byte patterns, bit 0 is the first bit on the wire
	// ------------------------------------------------------------
	localparam logic [7:0] SRM_CMD_WRITE = 8'h9d;
	localparam logic [7:0] SRM_CMD_READ  = 8'h62;

endpackage

// ==== logic/srm_sync.sv ====
module srm_sync #(
	parameter int WIDTH  = 3,
	parameter int STAGES = srm_pkg::SRM_SYNC_STAGES
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	// ------------------------------------------------------------
	// plain flop chain; only the last stage is visible outside
	// ------------------------------------------------------------
	logic [WIDTH-1:0] stage_q [STAGES];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < STAGES; i++)
				stage_q[i] <= '0;
		end
		else
		begin
			stage_q[0] <= d;
			for (int i = 1; i < STAGES; i++)
				stage_q[i] <= stage_q[i-1];
		end
	end

	assign q = stage_q[STAGES-1];

endmodule

// ==== logic/srm_store.sv ====
module srm_store #(
	parameter int DEPTH  = srm_pkg::SRM_DEPTH,
	parameter int WIDTH  = srm_pkg::SRM_BYTE_BITS,
	parameter int AWIDTH = srm_pkg::SRM_ADDR_BITS
) (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [AWIDTH-1:0] addr,
	input  wire logic [WIDTH-1:0]  wdata,
	output logic      [WIDTH-1:0]  rdata
);

	// ------------------------------------------------------------
	// byte array; contents survive the reset like the backed-up cells
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	assign rdata = mem[addr];

endmodule

// ==== logic/srm_core.sv ====
// Operation
// [R1] raising enable starts a cycle; a 24-bit address/command frame follows
// [R2] every input bit is captured on the link clock rising edge
// [R3] seven address bits select one of 128 byte locations
// [R4] host gives 24+8 clocks for one byte, 24+1024 for a burst
// [R5] bad first frame byte aborts; input ignored until enable cycles low-high
// [R6] read command pattern recognised in the first frame byte
// [R7] byte address taken from bits 0..6 of the second frame byte
// [R8] second byte bit 7 set aborts until enable cycles low-high
// [R9] any of third byte bits 0..6 set aborts until enable cycles
// [R10] zero address with third byte bit 7 set selects burst mode
// [R11] burst moves 128 consecutive bytes without interruption
// [R12] burst ends only when the host takes enable low; the code also halts it after location 127
// [R13] enable low ends any transfer and floats the data line
// [R14] host changes enable only while the link clock is high
// [R15] read data bits change on the link clock falling edge
// [R16] after a write frame, one byte is sampled on eight rising edges
// [R17] after a read frame, one byte is driven on eight falling edges
// [R18] write command carries bits 0..7 as 1,0,1,1,1,0,0,1
// [R19] read command carries bits 0..7 as 0,1,0,0,0,1,1,0
// [R20] host holds each input bit valid across its sampling rising edge
// [R21] each link clock cycle is a falling then a rising edge
// [R22] frame and data bytes travel least significant bit first
// [R23] burst starts at location zero and steps after every eight data clocks
module srm_core (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic                             xfer_en,
	input  wire logic                             sclk,
	input  wire logic                             dq_i,
	output logic                                  dq_o,
	output logic                                  dq_oe,
	output logic                                  cyc_active,
	output logic                                  cyc_abort,
	output logic                                  cyc_burst,
	output logic                                  cyc_write,
	output logic [srm_pkg::SRM_ADDR_BITS-1:0]     byte_addr
);

	// ------------------------------------------------------------
	// derived positions and counts
	// ------------------------------------------------------------
	localparam int FB = srm_pkg::SRM_FRAME_BITS;
	localparam int BB = srm_pkg::SRM_BYTE_BITS;
	localparam int AB = srm_pkg::SRM_ADDR_BITS;
	localparam int TOP_LSB = FB - BB;
	localparam int TOP_CTRL = TOP_LSB + srm_pkg::SRM_CTRL_BIT;
	localparam logic [4:0] CMD_LAST = 5'(BB - 1);
	localparam logic [4:0] ADDR_LAST = 5'(2 * BB - 1);
	localparam logic [4:0] FRAME_LAST = 5'(FB - 1);
	localparam logic [2:0] BIT_LAST = 3'(BB - 1);
	localparam logic [AB-1:0] ADDR_MAX = AB'(srm_pkg::SRM_DEPTH - 1);
	localparam logic [AB-1:0] ADDR_ZERO = '0;

	typedef enum logic [1:0] {
		st_idle,
		st_frame,
		st_data,
		st_halt
	} srm_state_e;

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	// enable, clock and data pass the same two stages, so their
	// relative timing on the wire is kept
	logic          en_s;
	logic          sclk_s;
	logic          dq_s;
	logic          sclk_prev_q;
	logic          sclk_rise;
	logic          sclk_fall;

	srm_sync #(
		.WIDTH  (3),
		.STAGES (srm_pkg::SRM_SYNC_STAGES)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({xfer_en, sclk, dq_i}),
		.q   ({en_s, sclk_s, dq_s})
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sclk_prev_q <= 1'b1;
		else
			sclk_prev_q <= sclk_s;
	end

	assign sclk_rise = sclk_s & ~sclk_prev_q;  // [R2]
	assign sclk_fall = ~sclk_s & sclk_prev_q;  // [R15]

	// ------------------------------------------------------------
	// state and frame checks
	// ------------------------------------------------------------
	srm_state_e      state_q;
	srm_state_e      state_d;
	logic [FB-1:0]   frame_q;
	logic [FB-1:0]   frame_next;
	logic [4:0]      frame_cnt_q;
	logic [2:0]      bit_idx_q;
	logic [BB-1:0]   cmd_byte;
	logic [AB-1:0]   frame_addr;
	logic            cmd_ok;
	logic            frame_fail;
	logic            frame_done;
	logic            byte_done;
	logic            more_bytes;
	logic            write_q;
	logic            burst_q;
	logic            abort_q;
	logic [AB-1:0]   addr_q;

	// new bits enter at the top, so the first bit ends up in bit 0
	assign frame_next = {dq_s, frame_q[FB-1:1]};  // [R22]
	assign cmd_byte   = frame_next[FB-1:TOP_LSB];
	assign frame_addr = frame_next[BB +: AB];  // [R7]
	assign cmd_ok     = (cmd_byte == srm_pkg::SRM_CMD_READ)  // [R6] [R19]
		|| (cmd_byte == srm_pkg::SRM_CMD_WRITE);  // [R18]

	always_comb
	begin
		frame_fail = 1'b0;
		if (state_q == st_frame && sclk_rise)
		begin
			if (frame_cnt_q == CMD_LAST && !cmd_ok)
				frame_fail = 1'b1;  // [R5]
			else if (frame_cnt_q == ADDR_LAST && frame_next[FB-1])
				frame_fail = 1'b1;  // [R8]
			else if (frame_cnt_q == FRAME_LAST && frame_next[TOP_CTRL-1:TOP_LSB] != '0)
				frame_fail = 1'b1;  // [R9]
		end
	end

	assign frame_done = state_q == st_frame && sclk_rise && frame_cnt_q == FRAME_LAST && !frame_fail;  // [R1]
	assign byte_done  = state_q == st_data && sclk_rise && bit_idx_q == BIT_LAST;
	assign more_bytes = burst_q && addr_q != ADDR_MAX;  // [R11]

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			st_idle:
				if (en_s)
					state_d = st_frame;  // [R1]
			st_frame:
				if (frame_fail)
					state_d = st_halt;  // [R5] [R8] [R9]
				else if (frame_done)
					state_d = st_data;
			st_data:
				if (byte_done && !more_bytes)
					state_d = st_halt;
			st_halt:
				state_d = st_halt;
			default:
				state_d = st_idle;
		endcase
		// enable low beats everything; a halted cycle only reopens from idle
		if (!en_s)
			state_d = st_idle;  // [R12] [R13]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= st_idle;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------
	// frame shifter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			frame_q     <= '0;
			frame_cnt_q <= '0;
		end
		else if (state_q != st_frame)
		begin
			frame_q     <= '0;
			frame_cnt_q <= '0;
		end
		else if (sclk_rise)
		begin
			frame_q     <= frame_next;  // [R2]
			frame_cnt_q <= frame_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// cycle attributes
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			write_q <= 1'b0;
		else if (state_q == st_frame && sclk_rise && frame_cnt_q == CMD_LAST)
			write_q <= cmd_byte == srm_pkg::SRM_CMD_WRITE;  // [R18]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			burst_q <= 1'b0;
		else if (state_q == st_idle)
			burst_q <= 1'b0;
		else if (frame_done)
			burst_q <= frame_next[FB-1] && frame_addr == ADDR_ZERO;  // [R10]
	end

	// the flag survives until the next cycle opens so software can see it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			abort_q <= 1'b0;
		else if (state_q == st_idle && en_s)
			abort_q <= 1'b0;
		else if (frame_fail)
			abort_q <= 1'b1;  // [R5]
	end

	// ------------------------------------------------------------
	// byte address
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_q <= '0;
		else if (frame_done)
			addr_q <= frame_addr;  // [R3] [R7] [R23]
		else if (byte_done && more_bytes)
			addr_q <= addr_q + AB'(1);  // [R23]
	end

	// ------------------------------------------------------------
	// data bit counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bit_idx_q <= '0;
		else if (state_q != st_data)
			bit_idx_q <= '0;
		else if (sclk_rise)
			bit_idx_q <= bit_idx_q + 3'h1;  // [R16] [R17]
	end

	// ------------------------------------------------------------
	// storage and write path
	// ------------------------------------------------------------
	logic [BB-1:0] wbuf_q;
	logic [BB-1:0] wdata;
	logic [BB-1:0] rdata;
	logic          mem_we;

	assign wdata  = {dq_s, wbuf_q[BB-1:1]};  // [R22]
	assign mem_we = byte_done && write_q;  // [R16]

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wbuf_q <= '0;
		else if (state_q == st_data && write_q && sclk_rise)
			wbuf_q <= wdata;  // [R2]
	end

	srm_store #(
		.DEPTH  (srm_pkg::SRM_DEPTH),
		.WIDTH  (BB),
		.AWIDTH (AB)
	) u_store (
		.clk   (clk),
		.we    (mem_we),
		.addr  (addr_q),
		.wdata (wdata),
		.rdata (rdata)
	);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// the byte is fetched on its first falling edge, after a burst step
	// has already moved the address
	logic [BB-1:0] rbyte_q;
	logic          dq_o_q;
	logic          dq_oe_q;
	logic          rd_phase;

	assign rd_phase = en_s && state_q == st_data && !write_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rbyte_q <= '0;
			dq_o_q  <= 1'b0;
			dq_oe_q <= 1'b0;
		end
		else if (!rd_phase)
		begin
			dq_o_q  <= 1'b0;
			dq_oe_q <= 1'b0;  // [R13]
		end
		else if (sclk_fall)
		begin
			dq_oe_q <= 1'b1;  // [R17]
			if (bit_idx_q == '0)
			begin
				rbyte_q <= rdata;
				dq_o_q  <= rdata[0];  // [R15] [R22]
			end
			else
				dq_o_q <= rbyte_q[bit_idx_q];  // [R15]
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dq_o       = dq_o_q;
	assign dq_oe      = dq_oe_q;
	assign cyc_active = state_q == st_frame || state_q == st_data;
	assign cyc_abort  = abort_q;
	assign cyc_burst  = burst_q;
	assign cyc_write  = write_q;
	assign byte_addr  = addr_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_bad_cmd;
		state_q == st_frame && sclk_rise && frame_cnt_q == CMD_LAST && !cmd_ok;
	endsequence

	sequence s_frame_ok;
		state_q == st_frame && sclk_rise && frame_cnt_q == FRAME_LAST && frame_next[TOP_CTRL-1:TOP_LSB] == '0;
	endsequence

	sequence s_burst_step;
		state_q == st_data && sclk_rise && bit_idx_q == BIT_LAST && burst_q && addr_q != ADDR_MAX && en_s;
	endsequence

	// own count of link rises in this cycle, so the store check does not lean
	// on the data bit counter that it guards
	localparam int RISE_W = $clog2(FB + BB * srm_pkg::SRM_DEPTH + 1);
	logic [RISE_W-1:0] chk_rises_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			chk_rises_q <= '0;
		else if (!en_s)
			chk_rises_q <= '0;
		else if (sclk_rise)
			chk_rises_q <= chk_rises_q + RISE_W'(1);
	end

	property p_bad_cmd_halts;
		s_bad_cmd ##1 en_s [*3] |-> state_q == st_halt && abort_q;
	endproperty
	a_bad_cmd_halts: assert property (p_bad_cmd_halts) else $error("bad command did not abort");  // [R5]

	property p_bit7_halts;
		state_q == st_frame && sclk_rise && frame_cnt_q == ADDR_LAST && frame_next[FB-1] && en_s
			|=> state_q == st_halt && abort_q;
	endproperty
	a_bit7_halts: assert property (p_bit7_halts) else $error("second byte bit 7 did not abort");  // [R8]

	property p_byte3_halts;
		state_q == st_frame && sclk_rise && frame_cnt_q == FRAME_LAST
			&& frame_next[TOP_CTRL-1:TOP_LSB] != '0 && en_s |=> state_q == st_halt;
	endproperty
	a_byte3_halts: assert property (p_byte3_halts) else $error("third byte low bits did not abort");  // [R9]

	property p_frame_to_data;
		s_frame_ok ##0 en_s |=> state_q == st_data && addr_q == $past(frame_addr);
	endproperty
	a_frame_to_data: assert property (p_frame_to_data) else $error("valid frame did not open data phase");  // [R1]

	property p_burst_select;
		s_frame_ok ##0 en_s ##0 frame_next[FB-1] && frame_addr == ADDR_ZERO |=> burst_q;
	endproperty
	a_burst_select: assert property (p_burst_select) else $error("burst not selected");  // [R10]

	property p_burst_step;
		s_burst_step |=> addr_q == $past(addr_q) + AB'(1) && state_q == st_data;
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst address did not step");  // [R23]

	property p_float_on_low;
		!en_s |=> !dq_oe && state_q == st_idle;
	endproperty
	a_float_on_low: assert property (p_float_on_low) else $error("data line driven with enable low");  // [R13]

	property p_out_on_fall;
		dq_oe && $changed(dq_o) |-> $past(sclk_fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("read bit moved off a falling edge");  // [R15]

	property p_write_on_rise;
		mem_we |-> sclk_rise && write_q && chk_rises_q >= RISE_W'(FB + BB - 1)
			&& 3'(chk_rises_q) == BIT_LAST;
	endproperty
	a_write_on_rise: assert property (p_write_on_rise) else $error("store written off the eighth rise");  // [R16]

	property p_halt_sticks;
		state_q == st_halt && en_s |=> state_q == st_halt;
	endproperty
	a_halt_sticks: assert property (p_halt_sticks) else $error("halted cycle resumed without enable low");  // [R12]

endmodule

// ==== bench/srm_host.sv ====
module srm_host (
	input  wire logic clk,
	input  wire logic dq_o,
	input  wire logic dq_oe,
	output logic      xfer_en,
	output logic      sclk,
	output logic      dq_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic drv_en = 1'b0;
	logic drv_d  = 1'b0;
	logic last_q = 1'b0;

	// a released line shows the inverse of its last level, never a stale copy
	always_comb dq_i = dq_oe ? dq_o : (drv_en ? drv_d : ~last_q);
	always_ff @(posedge clk) last_q <= dq_i;

	initial
	begin
		xfer_en = 1'b0;
		sclk    = 1'b1;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic open_cyc();
		xfer_en = 1'b1;
		idle(4);
	endtask

	// enable only moves while the link clock idles high
	task automatic close_cyc();
		xfer_en = 1'b0;
		drv_en  = 1'b0;
		idle(6);
	endtask

	// one fall then one rise; the bit is held from the fall to the next fall
	task automatic bit_xfer(input logic b, input logic drive, output logic s);
		sclk   = 1'b0;
		drv_en = drive;
		drv_d  = b;
		idle(4);
		sclk = 1'b1;
		idle(3);
		s = dq_i;
		idle(1);
	endtask

	task automatic byte_xfer(input logic [7:0] v, input logic drive, output logic [7:0] s);
		for (int i = 0; i < 8; i++)
		begin
			bit_xfer(v[i], drive, s[i]);
		end
	endtask

	task automatic frame(input logic [7:0] cmd, input logic [7:0] b2, input logic [7:0] b3);
		logic [7:0] s;
		byte_xfer(cmd, 1'b1, s);
		byte_xfer(b2, 1'b1, s);
		byte_xfer(b3, 1'b1, s);
	endtask
endmodule

// ==== bench/three_wire_serial_ram_test.sv ====
module three_wire_serial_ram_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       rst;
	logic       xfer_en;
	logic       sclk;
	logic       dq_i;
	logic       dq_o;
	logic       dq_oe;
	logic       cyc_active;
	logic       cyc_abort;
	logic       cyc_burst;
	logic       cyc_write;
	logic [6:0] byte_addr;
	int         error_cnt    = 0;
	int         total_checks = 0;

	srm_core uut (
		.clk        (clk),
		.rst        (rst),
		.xfer_en    (xfer_en),
		.sclk       (sclk),
		.dq_i       (dq_i),
		.dq_o       (dq_o),
		.dq_oe      (dq_oe),
		.cyc_active (cyc_active),
		.cyc_abort  (cyc_abort),
		.cyc_burst  (cyc_burst),
		.cyc_write  (cyc_write),
		.byte_addr  (byte_addr)
	);

	srm_host host (
		.clk     (clk),
		.dq_o    (dq_o),
		.dq_oe   (dq_oe),
		.xfer_en (xfer_en),
		.sclk    (sclk),
		.dq_i    (dq_i)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic test_reset();
		check("oe_rst", 8'(dq_oe), 8'h00);
		check("act_rst", 8'(cyc_active), 8'h00);
		check("addr_rst", 8'(byte_addr), 8'h00);
	endtask

	task automatic test_single();
		logic [6:0] a [3] = '{7'h55, 7'h7f, 7'h01};
		logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'h5a};
		logic [7:0] s;
		for (int i = 0; i < 3; i++)
		begin
			host.open_cyc();
			// burst bit set with a nonzero address must still give a single byte
			host.frame(srm_pkg::SRM_CMD_WRITE, {1'b0, a[i]}, 8'h80);
			check("wr_addr", 8'(byte_addr), 8'(a[i]));
			check("wr_single", 8'(cyc_burst), 8'h00);
			check("wr_kind", 8'(cyc_write), 8'h01);
			host.byte_xfer(d[i], 1'b1, s);
			check("wr_done", 8'(cyc_active), 8'h00);
			host.close_cyc();
		end
		for (int i = 0; i < 3; i++)
		begin
			host.open_cyc();
			host.frame(srm_pkg::SRM_CMD_READ, {1'b0, a[i]}, 8'h00);
			check("rd_kind", 8'(cyc_write), 8'h00);
			host.byte_xfer(8'h00, 1'b0, s);
			check("rd_data", s, d[i]);
			host.idle(2);
			check("rd_oe_end", 8'(dq_oe), 8'h00);
			host.close_cyc();
		end
	endtask

	task automatic test_abort();
		logic [7:0] f [4][3] = '{'{8'h9c, 8'h22, 8'h00}, '{8'h63, 8'h22, 8'h00},
			'{8'h9d, 8'ha2, 8'h00}, '{8'h9d, 8'h22, 8'h01}};
		logic [7:0] s;
		host.open_cyc();
		host.frame(srm_pkg::SRM_CMD_WRITE, 8'h22, 8'h00);
		host.byte_xfer(8'h11, 1'b1, s);
		host.close_cyc();
		for (int i = 0; i < 4; i++)
		begin
			host.open_cyc();
			host.frame(f[i][0], f[i][1], f[i][2]);
			check("abort_flag", 8'(cyc_abort), 8'h01);
			// the write attempt after the rejected frame must be ignored
			host.byte_xfer(8'hee, 1'b1, s);
			check("abort_oe", 8'(dq_oe), 8'h00);
			host.close_cyc();
		end
		host.open_cyc();
		host.frame(srm_pkg::SRM_CMD_READ, 8'h22, 8'h00);
		check("abort_clear", 8'(cyc_abort), 8'h00);
		host.byte_xfer(8'h00, 1'b0, s);
		check("abort_keep", s, 8'h11);
		host.close_cyc();
	endtask

	task automatic test_burst();
		logic [7:0] s;
		logic       b;
		host.open_cyc();
		host.frame(srm_pkg::SRM_CMD_WRITE, 8'h00, 8'h80);
		check("bw_mode", 8'(cyc_burst), 8'h01);
		for (int i = 0; i < 128; i++)
		begin
			check("bw_addr", 8'(byte_addr), 8'(i));
			host.byte_xfer(8'(i) ^ 8'hc3, 1'b1, s);
		end
		host.idle(2);
		check("bw_halt", 8'(cyc_active), 8'h00);
		host.close_cyc();
		host.open_cyc();
		host.frame(srm_pkg::SRM_CMD_READ, 8'h00, 8'h80);
		for (int i = 0; i < 128; i++)
		begin
			host.byte_xfer(8'h00, 1'b0, s);
			check("br_data", s, 8'(i) ^ 8'hc3);
		end
		host.close_cyc();
		// burst read cut short in mid-byte
		host.open_cyc();
		host.frame(srm_pkg::SRM_CMD_READ, 8'h00, 8'h80);
		host.byte_xfer(8'h00, 1'b0, s);
		host.bit_xfer(1'b0, 1'b0, b);
		host.bit_xfer(1'b0, 1'b0, b);
		check("br_live", 8'(dq_oe), 8'h01);
		host.close_cyc();
		check("br_float", 8'(dq_oe), 8'h00);
		check("br_end", 8'(cyc_active), 8'h00);
	endtask

	initial
	begin
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		host.idle(4);
		test_reset();
		test_single();
		test_abort();
		test_burst();
		close_out();
	end

	initial
	begin
		// the full run needs about 203 us of link traffic
		#600us;
		error_cnt++;
		close_out();
	end
endmodule
